// file: power_monitor_cfg.svh
/*
  Constants of the power monitor system register bank: port decode,
  pointer-space addresses, field positions and reset values.
  Assumes it is included by bare name from the files that need it.
*/
// What this block does
// - Pointer changes only by the set-pointer command
// - Status live bits are read-only to writes; a one written to a latched bit clears it
// - Status bits 15 to 13 read zero
// - Bit 12 shows mains detection failure
// - Alert bits 11,10 latch until host clears
// - Bits 9,3 show over-power per channel
// - Bits 8,2 show over-current per channel
// - Bits 7,5 give reactive power sign
// - Bits 6,4 give active power sign
// - Bit 1 latches line surge until cleared
// - Bit 0 latches line sag until cleared
// - Version returns fixed year-month-day-day code
// - Gain codes map 1..32, 110/111 give 1
// - Soft reset forces converter output to zero
// - Shutdown removes biases; clearing restores all
// - Shutdown entered only through the shutdown field
// - Reset field 11 both, 10 ch2, 01 ch1
// - Shutdown field 11 both, 10 ch2, 01 ch1
// - Gain ch2 bits 29:27, ch1 bits 26:24
`ifndef POWER_MONITOR_CFG_SVH
`define POWER_MONITOR_CFG_SVH

`define PORT_SET_POINTER 2'h0
`define PORT_DATA 2'h1

`define ADDR_POINTER 16'h0000
`define ADDR_STATUS 16'h0002
`define ADDR_VERSION 16'h0004
`define ADDR_SYSCFG 16'h00A0

`define BIT_MAINS_DETECT_FAIL 12
`define BIT_ALERT_TWO 11
`define BIT_ALERT_ONE 10
`define BIT_LINE_HIGH 1
`define BIT_LINE_LOW 0
`define STATUS_LATCH_MASK 13'h0C03
`define STATUS_LIVE_MASK 13'h13FC

`define CFG_GAIN2_LSB 27
`define CFG_GAIN1_LSB 24
`define CFG_RESET_LSB 5
`define CFG_SHDN_LSB 3
`define CFG_WRITE_MASK 32'h3F000078
`define CFG_RESET_VAL 32'h1B000000

`endif

// file: power_monitor_pkg.sv
/*
  Types shared by the register bank and the per-channel control.
  Assumes nothing of its surroundings.
*/
package power_monitor_pkg;
  typedef logic [2:0] gain_code_t;
  typedef logic [23:0] sample_t;
  typedef logic [5:0] gain_mult_t;
  typedef logic [12:0] flag_vec_t;
endpackage : power_monitor_pkg

// file: chan_ctl_if.sv
/*
  Configuration carried from the register bank to one channel control.
  Assumes the bank drives it and the channel only reads it.
*/
`timescale 1ns/1ps
interface chan_ctl_if;
  power_monitor_pkg::gain_code_t gain_code;
  logic soft_reset;
  logic shutdown;
  modport bank (output gain_code, output soft_reset, output shutdown);
  modport chan (input gain_code, input soft_reset, input shutdown);
endinterface : chan_ctl_if

// file: current_channel_ctl.sv
/*
  One current channel: gain decode, soft reset zeroing and shutdown
  of the converter. Assumes samples arrive on clk from the converter.
*/
`timescale 1ns/1ps
module current_channel_ctl (
  chan_ctl_if.chan cfg,
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire power_monitor_pkg::sample_t sample_in,
  output power_monitor_pkg::sample_t sample_out,
  output power_monitor_pkg::gain_mult_t gain_mult,
  output logic [2:0] power_en
);
  function automatic power_monitor_pkg::gain_mult_t gain_of(
    input power_monitor_pkg::gain_code_t code);
    unique case (code)
      3'h0: gain_of = 6'h01;
      3'h1: gain_of = 6'h02;
      3'h2: gain_of = 6'h04;
      3'h3: gain_of = 6'h08;
      3'h4: gain_of = 6'h10;
      3'h5: gain_of = 6'h20;
      default: gain_of = 6'h01;
    endcase
  endfunction : gain_of

  wire power_monitor_pkg::gain_mult_t next_gain_mult = gain_of(cfg.gain_code);
  // Soft reset keeps the converter running but blanks its result
  wire power_monitor_pkg::sample_t next_sample_out =
    (cfg.soft_reset || cfg.shutdown) ? 24'h000000 : sample_in;
  // Bit 2 digital, bit 1 clock, bit 0 analog bias
  wire [2:0] next_power_en = cfg.shutdown ? 3'h0 : 3'h7;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sample_out <= 24'h000000;
      gain_mult <= 6'h08;
      power_en <= 3'h7;
    end
    else if (ce)
    begin
      sample_out <= next_sample_out;
      gain_mult <= next_gain_mult;
      power_en <= next_power_en;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  gain_map_a: assert property (ce && cfg.gain_code[2:1] == 2'h3 |=>
    gain_mult == 6'h01) else $error("reserved gain code not unity");
  soft_zero_a: assert property (ce && cfg.soft_reset |=>
    sample_out == 24'h000000) else $error("soft reset output not zero");
  bias_off_a: assert property (ce && cfg.shutdown ##1 ce && !cfg.shutdown
    |=> power_en == 3'h7) else $error("biases not restored");
endmodule : current_channel_ctl

// file: power_monitor_status_config_regs.sv
/*
  System register bank of a dual-channel power monitor: address pointer,
  status word with latched alerts, engine date code and the system
  configuration word with gain, soft reset and shutdown per channel.
  Assumes a command interpreter on clk drives the register port and
  that the flag sources come from outside the clock domain.
*/
`timescale 1ns/1ps
`include "power_monitor_cfg.svh"
module power_monitor_status_config_regs #(
  // Arbitrary neutral date code, year A, month 1, day 01
  parameter logic [15:0] ENGINE_DATE = 16'hA101
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire power_monitor_pkg::flag_vec_t flag_src,
  input wire power_monitor_pkg::sample_t sample_ch1,
  input wire power_monitor_pkg::sample_t sample_ch2,
  output power_monitor_pkg::sample_t conv_out_ch1,
  output power_monitor_pkg::sample_t conv_out_ch2,
  output power_monitor_pkg::gain_mult_t gain_ch1,
  output power_monitor_pkg::gain_mult_t gain_ch2,
  output logic [2:0] power_en_ch1,
  output logic [2:0] power_en_ch2,
  output logic [15:0] pointer_out
);
  logic [15:0] register_pointer;
  power_monitor_pkg::flag_vec_t flag_meta;
  power_monitor_pkg::flag_vec_t flag_sync;
  power_monitor_pkg::flag_vec_t flag_latched;
  logic [31:0] sysconfig;

  chan_ctl_if ch1_if ();
  chan_ctl_if ch2_if ();

  // Pointer-space address match, used by reads and writes alike
  function automatic logic hit(input logic [15:0] ptr,
    input logic [15:0] target);
    hit = (ptr == target);
  endfunction : hit

  // Port decode: address 0 sets the pointer, address 1 reaches data, addresses 2 and 3 reach nothing
  wire cmd_set_ptr = reg_wr && (reg_addr == `PORT_SET_POINTER);
  wire data_wr = reg_wr && (reg_addr == `PORT_DATA);
  wire data_rd = reg_rd && (reg_addr == `PORT_DATA);
  wire ptr_rd = reg_rd && (reg_addr == `PORT_SET_POINTER);

  // Every data access goes to the word that the pointer selects
  wire sel_status = hit(register_pointer, `ADDR_STATUS);
  wire sel_version = hit(register_pointer, `ADDR_VERSION);
  wire sel_syscfg = hit(register_pointer, `ADDR_SYSCFG);
  wire wr_status = data_wr && sel_status;
  wire wr_syscfg = data_wr && sel_syscfg;

  wire [15:0] next_pointer = reg_wdata[15:0];

  // Writing a one to a latched bit clears it; live bits ignore writes
  wire [12:0] clear_req = wr_status ?
    (reg_wdata[12:0] & `STATUS_LATCH_MASK) : 13'h0000;
  // A new detection in the clearing cycle keeps the bit set
  wire [12:0] next_latched = (flag_latched & ~clear_req) |
    (flag_sync & `STATUS_LATCH_MASK);

  // Status word: latched alerts, live pin and algorithm states
  wire [15:0] system_flags = {3'h0,
    (flag_sync & `STATUS_LIVE_MASK) | flag_latched};
  // Over-current and both power signs pass through as live bits
  wire live_tags_unused = 1'b0;

  wire [31:0] next_sysconfig = reg_wdata & `CFG_WRITE_MASK;

  wire [31:0] data_word =
    sel_status ? {16'h0000, system_flags} :
    sel_version ? {16'h0000, ENGINE_DATE} :
    sel_syscfg ? sysconfig :
    32'h00000000;

  // Read data stand only in the cycle after the read strobe
  wire [31:0] next_rdata =
    data_rd ? data_word :
    ptr_rd ? {16'h0000, register_pointer} :
    32'h00000000;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag_meta <= 13'h0000;
      flag_sync <= 13'h0000;
    end
    else if (ce)
    begin
      flag_meta <= flag_src;
      flag_sync <= flag_meta;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      register_pointer <= 16'h0000;
    else if (ce && cmd_set_ptr)
      register_pointer <= next_pointer;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flag_latched <= 13'h0000;
    else if (ce)
      flag_latched <= next_latched;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sysconfig <= `CFG_RESET_VAL;
    else if (ce && wr_syscfg)
      sysconfig <= next_sysconfig;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h00000000;
      pointer_out <= 16'h0000;
    end
    else if (ce)
    begin
      reg_rdata <= next_rdata;
      pointer_out <= register_pointer;
    end
  end

  // Field split: low bit of each two-bit field is channel 1
  assign ch1_if.gain_code = sysconfig[`CFG_GAIN1_LSB +: 3];
  assign ch2_if.gain_code = sysconfig[`CFG_GAIN2_LSB +: 3];
  assign ch1_if.soft_reset = sysconfig[`CFG_RESET_LSB];
  assign ch2_if.soft_reset = sysconfig[`CFG_RESET_LSB + 1];
  assign ch1_if.shutdown = sysconfig[`CFG_SHDN_LSB];
  assign ch2_if.shutdown = sysconfig[`CFG_SHDN_LSB + 1];

  current_channel_ctl ch1_ctl (
    .cfg(ch1_if.chan),
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .sample_in(sample_ch1),
    .sample_out(conv_out_ch1),
    .gain_mult(gain_ch1),
    .power_en(power_en_ch1)
  );

  current_channel_ctl ch2_ctl (
    .cfg(ch2_if.chan),
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .sample_in(sample_ch2),
    .sample_out(conv_out_ch2),
    .gain_mult(gain_ch2),
    .power_en(power_en_ch2)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ptr_guard_a: assert property (!(ce && cmd_set_ptr) |=>
    register_pointer == $past(register_pointer))
    else $error("pointer changed without set command");

  ptr_load_a: assert property (ce && cmd_set_ptr |=>
    register_pointer == $past(reg_wdata[15:0]))
    else $error("set command did not load pointer");

  status_top_a: assert property (ce && data_rd && sel_status |=>
    reg_rdata[31:13] == 19'h00000)
    else $error("unimplemented status bits not zero");

  mains_bit_a: assert property (ce && data_rd && sel_status |=>
    reg_rdata[`BIT_MAINS_DETECT_FAIL] ==
    $past(flag_sync[`BIT_MAINS_DETECT_FAIL]))
    else $error("mains detect bit does not follow source");

  live_bits_a: assert property (ce && data_rd && sel_status |=>
    (reg_rdata[12:0] & `STATUS_LIVE_MASK) ==
    ($past(flag_sync) & `STATUS_LIVE_MASK))
    else $error("live status bits wrong");

  alert_hold_a: assert property (flag_latched[`BIT_ALERT_TWO] &&
    !(ce && wr_status && reg_wdata[`BIT_ALERT_TWO]) |=>
    flag_latched[`BIT_ALERT_TWO])
    else $error("alert two dropped without clear");

  surge_hold_a: assert property (flag_latched[`BIT_LINE_HIGH] &&
    !(ce && wr_status && reg_wdata[`BIT_LINE_HIGH]) |=>
    flag_latched[`BIT_LINE_HIGH])
    else $error("surge flag dropped without clear");

  sag_set_a: assert property (ce && flag_sync[`BIT_LINE_LOW] |=>
    flag_latched[`BIT_LINE_LOW])
    else $error("sag flag lost against clear");

  version_rd_a: assert property (ce && data_rd && sel_version |=>
    reg_rdata == {16'h0000, ENGINE_DATE})
    else $error("version code wrong");

  cfg_only_a: assert property (!(ce && wr_syscfg) |=>
    $stable(sysconfig))
    else $error("configuration changed without write");

  cfg_reset_a: assert property ($rose(rst_n) |->
    sysconfig == `CFG_RESET_VAL)
    else $error("configuration reset value wrong");

  rdata_gap_a: assert property (!(ce && reg_rd) && ce |=>
    reg_rdata == 32'h00000000)
    else $error("read data outside read slot");

  set_ptr_c: cover property (ce && cmd_set_ptr ##1 ce && data_rd);
  clear_race_c: cover property (ce && wr_status && |flag_sync[1:0]);
  shutdown_c: cover property (ce && wr_syscfg && reg_wdata[4:3] == 2'h3);
  soft_reset_c: cover property (ce && wr_syscfg && reg_wdata[6:5] == 2'h2);
endmodule : power_monitor_status_config_regs

// file: power_monitor_status_config_regs_tb.sv
/*
  Self-checking bench of the power monitor system register bank.
  Assumes the bank answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
`include "power_monitor_cfg.svh"
module power_monitor_status_config_regs_tb;
  localparam logic [15:0] DATE = 16'h2914; // Arbitrary date code
  localparam logic [23:0] S1 = 24'hA5C3E1;
  localparam logic [23:0] S2 = 24'h5A3C1E;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  power_monitor_pkg::flag_vec_t flag_src = 13'h0;
  power_monitor_pkg::sample_t conv_out_ch1, conv_out_ch2;
  power_monitor_pkg::gain_mult_t gain_ch1, gain_ch2;
  logic [2:0] power_en_ch1, power_en_ch2;
  logic [15:0] pointer_out;
  logic [31:0] q;
  int miscompares = 0;
  int comparisons = 0;

  `define check(got, exp) \
    begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
        miscompares++; \
        $display("MISMATCH %0t got %h expected %h", $time, got, exp); \
      end \
    end

  power_monitor_status_config_regs #(.ENGINE_DATE(DATE)) dut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flag_src(flag_src),
    .sample_ch1(S1), .sample_ch2(S2),
    .conv_out_ch1(conv_out_ch1), .conv_out_ch2(conv_out_ch2),
    .gain_ch1(gain_ch1), .gain_ch2(gain_ch2),
    .power_en_ch1(power_en_ch1), .power_en_ch2(power_en_ch2),
    .pointer_out(pointer_out)
  );

  initial
  begin
    forever #25 clk = ~clk;
  end

  task end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task peek(input logic [15:0] p, input logic [31:0] e);
    wr(`PORT_SET_POINTER, {16'h0, p});
    rd(`PORT_DATA, q);
    `check(q, e)
  endtask : peek

  task cfg(input logic [31:0] d);
    wr(`PORT_SET_POINTER, {16'h0, `ADDR_SYSCFG});
    wr(`PORT_DATA, d);
    repeat (3) @(posedge clk);
    #1;
  endtask : cfg

  function automatic power_monitor_pkg::gain_mult_t gexp(int c);
    return (c < 6) ? 6'(1 << c) : 6'h01;
  endfunction : gexp

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `check(gain_ch1, 6'h08)
    `check(gain_ch2, 6'h08)
    `check(power_en_ch1, 3'h7)
    peek(`ADDR_SYSCFG, `CFG_RESET_VAL);
    // Pointer is reachable only by the set-pointer port
    wr(`PORT_SET_POINTER, {16'h0, `ADDR_POINTER});
    wr(`PORT_DATA, 32'h0000_00A0);
    rd(`PORT_SET_POINTER, q);
    `check(q, 32'h0)
    @(posedge clk);
    #1;
    `check(pointer_out, 16'h0000)
    // Each status source alone: live bits follow, latched bits hold
    for (int i = 0; i < 13; i++)
    begin
      flag_src <= 13'(1 << i);
      repeat (5) @(posedge clk);
      peek(`ADDR_STATUS, 32'(1 << i));
      flag_src <= 13'h0;
      repeat (5) @(posedge clk);
      peek(`ADDR_STATUS, 32'(1 << i) & 32'h0C03);
      wr(`PORT_DATA, 32'hFFFF_FFFF);
      rd(`PORT_DATA, q);
      `check(q, 32'h0)
    end
    // Writes cannot disturb live status bits
    flag_src <= 13'h13FC;
    repeat (5) @(posedge clk);
    wr(`PORT_DATA, 32'hFFFF_FFFF);
    rd(`PORT_DATA, q);
    `check(q, 32'h0000_13FC)
    // A clear while the source still stands leaves the latch set
    flag_src <= 13'h0C03;
    repeat (5) @(posedge clk);
    wr(`PORT_DATA, 32'hFFFF_FFFF);
    rd(`PORT_DATA, q);
    `check(q, 32'h0000_0C03)
    flag_src <= 13'h0;
    repeat (5) @(posedge clk);
    wr(`PORT_DATA, 32'hFFFF_FFFF);
    rd(`PORT_DATA, q);
    `check(q, 32'h0)
    peek(`ADDR_VERSION, {16'h0, DATE});
    wr(`PORT_DATA, 32'h0000_0000);
    rd(`PORT_DATA, q);
    `check(q, {16'h0, DATE})
    // Every gain code on both channels
    for (int c = 0; c < 8; c++)
    begin
      cfg({2'b00, 3'(7 - c), 3'(c), 24'h0});
      `check(gain_ch1, gexp(c))
      `check(gain_ch2, gexp(7 - c))
    end
    // Soft reset and shutdown codes
    for (int m = 0; m < 4; m++)
    begin
      cfg(`CFG_RESET_VAL | 32'(m << 5));
      `check(conv_out_ch1, m[0] ? 24'h0 : S1)
      `check(conv_out_ch2, m[1] ? 24'h0 : S2)
      `check(power_en_ch1 & power_en_ch2, 3'h7)
      cfg(`CFG_RESET_VAL | 32'(m << 3));
      `check(power_en_ch1, m[0] ? 3'h0 : 3'h7)
      `check(power_en_ch2, m[1] ? 3'h0 : 3'h7)
    end
    cfg(`CFG_RESET_VAL);
    `check(power_en_ch2, 3'h7)
    `check(conv_out_ch2, S2)
    cfg(32'hFFFF_FFFF);
    peek(`ADDR_SYSCFG, `CFG_WRITE_MASK);
    rd(2'h2, q);
    `check(q, 32'h0)
    peek(16'h0006, 32'h0);
    end_sim();
  end
endmodule : power_monitor_status_config_regs_tb
